// ==== mcr_pkg.sv ====
package mcr_pkg;
	// ****************************************
	// Special-register addresses
	// ****************************************
	localparam logic [31:0] MCR_ADDR_CAP      = 32'h0000_0100;
	localparam logic [31:0] MCR_ADDR_GSTATE   = 32'h0000_0101;
	localparam logic [31:0] MCR_ADDR_GENABLE  = 32'h0000_0102;
	localparam logic [31:0] MCR_ADDR_LTYPE    = 32'h0000_0103;
	localparam logic [31:0] MCR_ADDR_LADDR    = 32'h0000_0104;
	localparam logic [31:0] MCR_ADDR_EXT_BASE = 32'h0000_0180;
	localparam logic [31:0] MCR_ADDR_BANK0    = 32'h0000_0400;
	localparam logic [1:0]  MCR_BANK_CTL      = 2'h0;
	localparam logic [1:0]  MCR_BANK_STATUS   = 2'h1;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int MCR_CAP_CTL_P   = 8;
	localparam int MCR_CAP_EXT_P   = 9;
	localparam int MCR_CAP_EXT_LO  = 16;
	localparam int MCR_GS_RESTART  = 0;
	localparam int MCR_GS_ERRPTR   = 1;
	localparam int MCR_GS_INPROG   = 2;
	localparam int MCR_ST_VALID    = 63;
	localparam int MCR_ST_OVER     = 62;
	localparam int MCR_ST_UC       = 61;
	localparam int MCR_ST_EN       = 60;
	localparam int MCR_LT_PARITY   = 0;
	localparam int MCR_LT_BUSFAIL  = 1;
	localparam logic [63:0] MCR_ALL_ONES  = 64'hFFFF_FFFF_FFFF_FFFF;
	localparam logic [63:0] MCR_ALL_ZEROS = 64'h0000_0000_0000_0000;
	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic        valid;
		logic [2:0]  bank;
		logic [5:0]  flag;
		logic        uc;
		logic [15:0] code;
		logic        restart_ok;
		logic        ptr_related;
	} mcr_err_s;
	typedef struct packed {
		logic        valid;
		logic        parity;
		logic [63:0] addr;
	} mcr_legacy_s;
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [31:0] addr;
		logic [63:0] wdata;
	} mcr_sreq_s;
	typedef struct packed {
		logic        done;
		logic        fault;
		logic [63:0] rdata;
	} mcr_sresp_s;
endpackage

// ==== mcr_regs.sv ====
`timescale 1ns/1ps
module mcr_regs import mcr_pkg::*; #(
	parameter int          N_BANKS     = 5,
	parameter bit          NEWER       = 1'b1,
	parameter bit          CTL_PRESENT = 1'b1,
	parameter bit          EXT_PRESENT = 1'b1,
	parameter logic [7:0]  EXT_CNT     = 8'h0A,
	parameter logic [63:0] IMPL_MASK   = 64'hFFFF_FFFF_FFFF_FFFF
) (
	input  wire logic        clock,         // Core clock
	input  wire logic        srst,          // Synchronous reset, high
	input  wire mcr_sreq_s   sreq,          // Special-register read/write request
	output mcr_sresp_s       sresp,         // Answer one cycle later
	input  wire mcr_err_s    err,           // Error report from a hardware unit
	input  wire mcr_legacy_s legacy,        // Legacy parity or bus-cycle failure
	input  wire logic        legacy_mode,   // Legacy compatibility mode
	output logic             check_exception, // One-cycle exception pulse
	output logic             shutdown       // Processor shutdown, sticky
);
	// ****************************************
	// State
	// ****************************************
	logic [63:0] ctl_ff [N_BANKS];
	logic [63:0] nxt_ctl [N_BANKS];
	logic [63:0] sts_ff [N_BANKS];
	logic [63:0] nxt_sts [N_BANKS];
	logic        genable_ff, nxt_genable;
	logic [2:0]  gstate_ff, nxt_gstate;
	logic [63:0] ltype_ff, nxt_ltype;
	logic [63:0] laddr_ff, nxt_laddr;
	logic        lpend_ff, nxt_lpend;
	logic        exc_ff, nxt_exc;
	logic        shut_ff, nxt_shut;
	mcr_sresp_s  resp_ff, nxt_resp;
	logic [63:0] cap_val;
	logic [31:0] boff;
	logic [2:0]  bidx;
	logic        bank_hit;
	logic        ev;
	logic        raise;
	logic        trigger;
	logic        glob_en;

	// Capability word; earlier variant keeps bits 63:9 at zero
	always_comb begin
		cap_val = '0;
		cap_val[7:0] = 8'(N_BANKS);
		cap_val[MCR_CAP_CTL_P] = CTL_PRESENT;
		if (NEWER) begin
			cap_val[MCR_CAP_EXT_P] = EXT_PRESENT;
			cap_val[MCR_CAP_EXT_LO +: 8] = EXT_PRESENT ? EXT_CNT : 8'h00;
		end
	end

	// Bank decode and event qualification
	assign boff     = sreq.addr - MCR_ADDR_BANK0;
	assign bidx     = boff[4:2];
	assign bank_hit = (sreq.addr >= MCR_ADDR_BANK0) && (boff < 32'(4 * N_BANKS));
	// Without a global enable register checking is treated as always on
	assign glob_en  = CTL_PRESENT ? genable_ff : 1'b1;
	assign ev       = err.valid && (32'(err.bank) < 32'(N_BANKS));
	assign raise    = ev && glob_en && ctl_ff[err.bank][err.flag];
	assign trigger  = raise || lpend_ff;

	// ****************************************
	// Next-state logic
	// ****************************************
	// Software access first, hardware events after, so a set wins over a clear
	always_comb begin
		logic [63:0] old;
		logic        ow;
		old = '0;
		ow = 1'b0;
		nxt_ctl = ctl_ff;
		nxt_sts = sts_ff;
		nxt_genable = genable_ff;
		nxt_gstate = gstate_ff;
		nxt_ltype = ltype_ff;
		nxt_laddr = laddr_ff;
		nxt_lpend = 1'b0;
		nxt_exc = 1'b0;
		nxt_shut = shut_ff;
		nxt_resp = '0;
		nxt_resp.done = sreq.rd || sreq.wr;
		if (sreq.rd) begin
			if (sreq.addr == MCR_ADDR_CAP) begin
				nxt_resp.rdata = cap_val;
			end else if (sreq.addr == MCR_ADDR_GSTATE) begin
				nxt_resp.rdata = {61'h0, gstate_ff};
			end else if (sreq.addr == MCR_ADDR_GENABLE && CTL_PRESENT) begin
				nxt_resp.rdata = genable_ff ? MCR_ALL_ONES : MCR_ALL_ZEROS;
			end else if (sreq.addr == MCR_ADDR_LTYPE) begin
				nxt_resp.rdata = ltype_ff;
			end else if (sreq.addr == MCR_ADDR_LADDR) begin
				nxt_resp.rdata = laddr_ff;
			end else if (NEWER && EXT_PRESENT && sreq.addr >= MCR_ADDR_EXT_BASE
					&& sreq.addr < MCR_ADDR_EXT_BASE + 32'(EXT_CNT)) begin
				nxt_resp.rdata = '0; // Saved state not kept here
			end else if (bank_hit && boff[1:0] == MCR_BANK_CTL) begin
				nxt_resp.rdata = ctl_ff[bidx];
			end else if (bank_hit && boff[1:0] == MCR_BANK_STATUS) begin
				nxt_resp.rdata = sts_ff[bidx];
			end else begin
				nxt_resp.fault = 1'b1;
			end
		end else if (sreq.wr) begin
			if (sreq.addr == MCR_ADDR_GSTATE) begin
				nxt_gstate = sreq.wdata[2:0];
			end else if (sreq.addr == MCR_ADDR_GENABLE && CTL_PRESENT) begin
				// Any other pattern is ignored rather than guessed at
				if (sreq.wdata == MCR_ALL_ONES) begin
					nxt_genable = 1'b1;
				end else if (sreq.wdata == MCR_ALL_ZEROS) begin
					nxt_genable = 1'b0;
				end
			end else if (bank_hit && boff[1:0] == MCR_BANK_CTL) begin
				if (NEWER || sreq.wdata == MCR_ALL_ONES || sreq.wdata == MCR_ALL_ZEROS) begin
					nxt_ctl[bidx] = (sreq.wdata & IMPL_MASK) | (ctl_ff[bidx] & ~IMPL_MASK);
				end
			end else if (bank_hit && boff[1:0] == MCR_BANK_STATUS) begin
				if (sreq.wdata == MCR_ALL_ZEROS) begin
					nxt_sts[bidx] = '0;
				end else begin
					nxt_resp.fault = 1'b1;
				end
			end else begin
				nxt_resp.fault = 1'b1; // Capability and legacy logs are read-only
			end
		end
		// Error logging into the bank, merged over any software clear
		if (ev) begin
			old = nxt_sts[err.bank];
			ow = !old[MCR_ST_VALID] || (!old[MCR_ST_UC] && (err.uc
				|| (ctl_ff[err.bank][err.flag] && !old[MCR_ST_EN])));
			if (ow) begin
				nxt_sts[err.bank] = '0;
				nxt_sts[err.bank][15:0] = err.code;
				nxt_sts[err.bank][MCR_ST_UC] = err.uc;
				nxt_sts[err.bank][MCR_ST_EN] = ctl_ff[err.bank][err.flag];
			end
			nxt_sts[err.bank][MCR_ST_OVER] = old[MCR_ST_OVER] | old[MCR_ST_VALID];
			nxt_sts[err.bank][MCR_ST_VALID] = 1'b1;
		end
		// Legacy errors are logged now and raise the exception next cycle
		if (legacy.valid && legacy_mode) begin
			nxt_ltype = '0;
			nxt_ltype[MCR_LT_PARITY] = legacy.parity;
			nxt_ltype[MCR_LT_BUSFAIL] = !legacy.parity;
			nxt_laddr = legacy.addr;
			nxt_lpend = 1'b1;
		end
		if (trigger) begin
			if (gstate_ff[MCR_GS_INPROG]) begin
				nxt_shut = 1'b1;
			end else begin
				nxt_exc = 1'b1;
				nxt_gstate[MCR_GS_INPROG] = 1'b1;
				nxt_gstate[MCR_GS_RESTART] = raise && err.restart_ok;
				nxt_gstate[MCR_GS_ERRPTR] = raise && err.ptr_related;
			end
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	// Enables reset to zero: firmware arms checking after boot
	always_ff @(posedge clock) begin
		if (srst) begin
			for (int i = 0; i < N_BANKS; i++) begin
				ctl_ff[i] <= '0;
				sts_ff[i] <= '0;
			end
			genable_ff <= 1'b0;
			gstate_ff <= 3'h0;
			ltype_ff <= '0;
			laddr_ff <= '0;
			lpend_ff <= 1'b0;
			exc_ff <= 1'b0;
			shut_ff <= 1'b0;
			resp_ff <= '0;
		end else begin
			ctl_ff <= nxt_ctl;
			sts_ff <= nxt_sts;
			genable_ff <= nxt_genable;
			gstate_ff <= nxt_gstate;
			ltype_ff <= nxt_ltype;
			laddr_ff <= nxt_laddr;
			lpend_ff <= nxt_lpend;
			exc_ff <= nxt_exc;
			shut_ff <= nxt_shut;
			resp_ff <= nxt_resp;
		end
	end

	assign sresp = resp_ff;
	assign check_exception = exc_ff;
	assign shutdown = shut_ff;

	// ****************************************
	// Assertions
	// ****************************************
	sequence s_legacy_quiet;
		legacy.valid && legacy_mode && !gstate_ff[MCR_GS_INPROG] && !lpend_ff && !raise && !sreq.wr;
	endsequence
	sequence s_logged_then_raised;
		(ltype_ff != 64'h0) ##1 check_exception;
	endsequence

	property p_exc_sets_inprog;
		@(posedge clock) disable iff (srst) check_exception |-> gstate_ff[MCR_GS_INPROG];
	endproperty
	a_exc_sets_inprog: assert property (p_exc_sets_inprog) else $error("in-progress not set");

	property p_second_shutdown;
		@(posedge clock) disable iff (srst) (trigger && gstate_ff[MCR_GS_INPROG]) |=> shutdown && !check_exception;
	endproperty
	a_second_shutdown: assert property (p_second_shutdown) else $error("no shutdown");

	property p_cap_read;
		@(posedge clock) disable iff (srst) (sreq.rd && sreq.addr == MCR_ADDR_CAP)
			|=> sresp.done && sresp.rdata[7:0] == 8'(N_BANKS) && sresp.rdata[MCR_CAP_CTL_P] == CTL_PRESENT;
	endproperty
	a_cap_read: assert property (p_cap_read) else $error("bad capability");

	property p_status_ones_fault;
		@(posedge clock) disable iff (srst) (sreq.wr && !sreq.rd && bank_hit && boff[1:0] == MCR_BANK_STATUS
			&& sreq.wdata != MCR_ALL_ZEROS) |=> sresp.fault;
	endproperty
	a_status_ones_fault: assert property (p_status_ones_fault) else $error("no fault");

	property p_log_valid;
		@(posedge clock) disable iff (srst) ev |=> sts_ff[$past(err.bank)][MCR_ST_VALID];
	endproperty
	a_log_valid: assert property (p_log_valid) else $error("valid not set");

	property p_overflow;
		@(posedge clock) disable iff (srst) (ev && sts_ff[err.bank][MCR_ST_VALID]) |=> sts_ff[$past(err.bank)][MCR_ST_OVER];
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow not set");

	property p_genable_other;
		@(posedge clock) disable iff (srst) (sreq.wr && !sreq.rd && sreq.addr == MCR_ADDR_GENABLE
			&& sreq.wdata != MCR_ALL_ONES && sreq.wdata != MCR_ALL_ZEROS) |=> $stable(genable_ff);
	endproperty
	a_genable_other: assert property (p_genable_other) else $error("enable changed");

	property p_gated;
		@(posedge clock) disable iff (srst) (!lpend_ff && !(ev && glob_en && ctl_ff[err.bank][err.flag])) |=> !check_exception;
	endproperty
	a_gated: assert property (p_gated) else $error("ungated exception");

	property p_legacy_order;
		@(posedge clock) disable iff (srst) s_legacy_quiet |=> s_logged_then_raised;
	endproperty
	a_legacy_order: assert property (p_legacy_order) else $error("legacy order wrong");
endmodule // mcr_regs

// ==== mcr_err_src.sv ====
`timescale 1ns/1ps
module mcr_err_src import mcr_pkg::*; (
	input  wire logic       clock, // Core clock
	input  wire logic       srst,  // Synchronous reset, high
	input  wire logic       go,    // Start one report
	input  wire logic [3:0] dly,   // Cycles to wait before reporting
	input  wire mcr_err_s   cmd,   // Report contents
	output mcr_err_s        err    // Report towards the checked block
);
	// ****************************************
	// Slow or prompt hardware unit
	// ****************************************
	logic [3:0] cnt_ff, nxt_cnt;
	logic       busy_ff, nxt_busy;
	mcr_err_s   err_ff, nxt_err;
	// Idle fields flip every cycle, so stale data never passes for a report
	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_busy = busy_ff;
		nxt_err = ~err_ff;
		nxt_err.valid = 1'b0;
		if (go) begin
			nxt_cnt = dly;
			nxt_busy = 1'b1;
		end else if (busy_ff && cnt_ff == 4'h0) begin
			nxt_err = cmd;
			nxt_err.valid = 1'b1; // One-cycle pulse per report
			nxt_busy = 1'b0;
		end else if (busy_ff) begin
			nxt_cnt = cnt_ff - 4'h1;
		end
	end
	// State registers
	always_ff @(posedge clock) begin
		if (srst) begin
			cnt_ff <= 4'h0;
			busy_ff <= 1'b0;
			err_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
			busy_ff <= nxt_busy;
			err_ff <= nxt_err;
		end
	end
	assign err = err_ff;
endmodule // mcr_err_src

// ==== tb_machine_check_regs.sv ====
`timescale 1ns/1ps
module tb_machine_check_regs;
	import mcr_pkg::*;
	localparam int NB = 5;
	logic        clock = 1'b0;
	logic        srst = 1'b1;
	logic        legacy_mode = 1'b0;
	logic        go = 1'b0;
	logic [3:0]  dly = 4'h0;
	mcr_sreq_s   sreq = '0;
	mcr_sreq_s   sreq_old = '0;
	mcr_err_s    cmd = '0;
	mcr_legacy_s legacy = '0;
	mcr_sresp_s  sresp;
	mcr_sresp_s  sresp_old;
	mcr_err_s    err;
	logic        check_exception;
	logic        shutdown;
	int          fails = 0;
	int          samples_checked = 0;
	logic [63:0] en [NB];
	logic [63:0] rdat;
	logic        flt;
	logic [63:0] rdat_old;
	logic        flt_old;
	logic        exc;
	int          b;
	int          k;
	// 50 MHz core clock
	always #10 clock = ~clock;
	mcr_regs #(.N_BANKS(NB)) u_mcr_regs (.clock(clock), .srst(srst), .sreq(sreq), .sresp(sresp), .err(err),
		.legacy(legacy), .legacy_mode(legacy_mode), .check_exception(check_exception), .shutdown(shutdown));
	mcr_err_src u_mcr_err_src (.clock(clock), .srst(srst), .go(go), .dly(dly), .cmd(cmd), .err(err));
	// Earlier variant without global enable; only its register answers are watched
	mcr_regs #(.N_BANKS(NB), .NEWER(1'b0), .CTL_PRESENT(1'b0)) u_mcr_regs_old (.clock(clock), .srst(srst),
		.sreq(sreq_old), .sresp(sresp_old), .err(err), .legacy(legacy), .legacy_mode(legacy_mode),
		.check_exception(), .shutdown());
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic wrap_up();
		if (fails == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Expected bank status word
	function automatic logic [63:0] st(input logic e, input logic u, input logic o, input logic [15:0] c);
		return {1'b1, o, u, e, 44'h0, c};
	endfunction
	// One access; request held until the edge that takes it, answer one cycle later
	task automatic acc(input logic w, input logic [31:0] a, input logic [63:0] d);
		@(posedge clock);
		sreq <= '{rd: ~w, wr: w, addr: a, wdata: d};
		// Earlier variant never sees a bank 0 enable write, firmware owns it
		sreq_old <= '{rd: ~w, wr: w && a != MCR_ADDR_BANK0, addr: a, wdata: d};
		@(posedge clock);
		sreq <= '0;
		sreq_old <= '0;
		#1;
		chk("done", 64'h1, 64'(sresp.done));
		rdat = sresp.rdata;
		flt = sresp.fault;
		rdat_old = sresp_old.rdata;
		flt_old = sresp_old.fault;
	endtask
	task automatic rchk(input string what, input logic [31:0] a, input logic [63:0] exp);
		acc(1'b0, a, 64'h0);
		chk(what, exp, rdat);
		chk("read fault", 64'h0, 64'(flt));
	endtask
	// Report through the partner at a random delay, then sample the exception cycle
	task automatic inject(input logic [2:0] bk, input logic [5:0] fl, input logic uc, output logic ex);
		int i;
		@(posedge clock);
		cmd <= '{valid: 1'b1, bank: bk, flag: fl, uc: uc, code: 16'($urandom), restart_ok: 1'($urandom),
			ptr_related: 1'($urandom)};
		dly <= 4'($urandom % 6);
		go <= 1'b1;
		@(posedge clock);
		go <= 1'b0;
		for (i = 0; i < 20 && err.valid !== 1'b1; i++) begin
			@(posedge clock);
			#1;
		end
		@(posedge clock);
		#1;
		ex = check_exception;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		void'($urandom(40637));
		repeat (10) @(posedge clock);
		srst <= 1'b0;
		rchk("capability", MCR_ADDR_CAP, {40'h0, 8'h0A, 6'h0, 1'b1, 1'b1, 8'(NB)});
		chk("earlier capability", {55'h0, 1'b0, 8'(NB)}, rdat_old);
		rchk("global state", MCR_ADDR_GSTATE, 64'h0);
		rchk("extended", MCR_ADDR_EXT_BASE, 64'h0);
		chk("earlier extended fault", 64'h1, 64'(flt_old));
		acc(1'b1, MCR_ADDR_CAP, MCR_ALL_ONES);
		chk("capability write fault", 64'h1, 64'(flt));
		acc(1'b0, MCR_ADDR_BANK0 + 32'h2, 64'h0);
		chk("bank address fault", 64'h1, 64'(flt));
		acc(1'b1, MCR_ADDR_GENABLE, 64'h5);
		chk("earlier enable absent", 64'h1, 64'(flt_old));
		rchk("global enable odd", MCR_ADDR_GENABLE, 64'h0);
		acc(1'b1, MCR_ADDR_GENABLE, MCR_ALL_ONES);
		rchk("global enable", MCR_ADDR_GENABLE, MCR_ALL_ONES);
		// Random enables; the earlier variant refuses mixed words and stays zero
		for (b = 0; b < NB; b++) begin
			en[b] = {32'($urandom), 32'($urandom)};
			acc(1'b1, MCR_ADDR_BANK0 + 32'(4 * b), en[b]);
			rchk("bank enable", MCR_ADDR_BANK0 + 32'(4 * b), en[b]);
			chk("earlier bank enable", 64'h0, rdat_old);
		end
		// Random reports; a clear flag must log without raising the exception
		for (k = 0; k < 12; k++) begin
			b = $urandom % NB;
			inject(3'(b), 6'($urandom), 1'($urandom), exc);
			chk("exception", 64'(en[b][cmd.flag]), 64'(exc));
			rchk("status", MCR_ADDR_BANK0 + 32'(4 * b + 1), st(en[b][cmd.flag], cmd.uc, 1'b0, cmd.code));
			if (exc === 1'b1) begin
				rchk("state", MCR_ADDR_GSTATE, {61'h0, 1'b1, cmd.ptr_related, cmd.restart_ok});
			end else begin
				rchk("state idle", MCR_ADDR_GSTATE, 64'h0);
			end
			acc(1'b1, MCR_ADDR_BANK0 + 32'(4 * b + 1), 64'h0);
			acc(1'b1, MCR_ADDR_GSTATE, 64'h0);
		end
		// Nested event while in progress, with overflow over a corrected entry
		acc(1'b1, MCR_ADDR_BANK0 + 32'h4, MCR_ALL_ONES);
		rchk("bank 1 enable", MCR_ADDR_BANK0 + 32'h4, MCR_ALL_ONES);
		chk("earlier bank all ones", MCR_ALL_ONES, rdat_old);
		inject(3'h1, 6'h3, 1'b0, exc);
		chk("first exception", 64'h1, 64'(exc));
		inject(3'h1, 6'h7, 1'b1, exc);
		chk("nested exception", 64'h0, 64'(exc));
		chk("shutdown", 64'h1, 64'(shutdown));
		rchk("overflow", MCR_ADDR_BANK0 + 32'h5, st(1'b1, 1'b1, 1'b1, cmd.code));
		acc(1'b1, MCR_ADDR_BANK0 + 32'h5, 64'h1);
		chk("status ones fault", 64'h1, 64'(flt));
		// Second reset mid-run clears shutdown and enables
		@(posedge clock);
		srst <= 1'b1;
		repeat (2) @(posedge clock);
		srst <= 1'b0;
		#1;
		chk("shutdown after reset", 64'h0, 64'(shutdown));
		rchk("enable after reset", MCR_ADDR_GENABLE, 64'h0);
		// Legacy parity error: logged first, exception one cycle later
		@(posedge clock);
		legacy_mode <= 1'b1;
		legacy <= '{valid: 1'b1, parity: 1'b1, addr: {32'($urandom), 32'($urandom)}};
		@(posedge clock);
		legacy.valid <= 1'b0;
		#1;
		chk("legacy early exception", 64'h0, 64'(check_exception));
		@(posedge clock);
		#1;
		chk("legacy exception", 64'h1, 64'(check_exception));
		rchk("legacy type", MCR_ADDR_LTYPE, 64'h1);
		rchk("legacy address", MCR_ADDR_LADDR, legacy.addr);
		// Software clears then sets the in-progress flag; a bus failure must then shut down
		acc(1'b1, MCR_ADDR_GSTATE, 64'h0);
		rchk("state cleared", MCR_ADDR_GSTATE, 64'h0);
		acc(1'b1, MCR_ADDR_GSTATE, 64'h4);
		@(posedge clock);
		legacy <= '{valid: 1'b1, parity: 1'b0, addr: 64'h0};
		@(posedge clock);
		legacy.valid <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
		chk("shutdown from software flag", 64'h1, 64'(shutdown));
		rchk("legacy bus failure", MCR_ADDR_LTYPE, 64'h2);
		wrap_up();
	end
	// Watchdog well beyond the expected run length
	initial begin
		repeat (5000) @(posedge clock);
		fails++;
		wrap_up();
	end
endmodule // tb_machine_check_regs
